// *** rtl/disconnect_timer.sv ***
// disconnect timer for the detachable operating unit
`timescale 1ns/1ns
`default_nettype none
module disconnect_timer #(
  parameter int unsigned THRESHOLD = rps_pkg::DISC_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control and presence
  input wire logic detect_en,
  input wire logic unit_present,
  // results
  output logic trip_pulse,
  output logic armed
);

  localparam logic [rps_pkg::TIMER_W-1:0] THR =
    rps_pkg::TIMER_W'(THRESHOLD);

  typedef struct packed {
    logic [rps_pkg::TIMER_W-1:0] count; // cycles of absence
    logic armed;                        // unit seen since power-on
    logic fired;                        // one trip per absence
    logic pulse;                        // trip request
  } timer_s;

  timer_s r;
  timer_s n;

  // count absence, restart on return or when detection is off
  always_comb begin
    n = r;
    n.pulse = 1'b0;
    // absent since power-on is never a fault
    if (unit_present) begin
      n.armed = 1'b1;
    end
    if (!detect_en || unit_present || !r.armed) begin
      n.count = '0;
      n.fired = 1'b0;
    end else if (!r.fired) begin
      // trip only once the absence outlasts the threshold
      if (r.count == THR) begin
        n.pulse = 1'b1;
        n.fired = 1'b1;
      end else begin
        n.count = r.count + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign trip_pulse = r.pulse;
  assign armed = r.armed;

endmodule
`default_nettype wire

// *** rtl/reset_panel_stop_select.sv ***
// reset acceptance, unit disconnect trip and panel stop selection
//
// Overview of operation
// - reset from terminal and communication, gated
// - trip-only settings accept reset when tripped
// - setting defaults to 14; legal 0-3, 14-17
// - absence beyond 1s trips with disconnect code
// - settings 0,1,14,15 disable disconnect detection
// - settings 0-3: stop key only in panel
// - settings 14-17: stop key in every mode
// - setting writable despite write protection
// - parameter clears leave the setting untouched
// - accepted reset shuts off drive output
// - accepted reset clears thermal and regen totals
// - panel reset key works only when tripped
// - unit absent at power-on is no fault
// - stop state blocks restart until reset
// - rs485 on connector disables detection only
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module reset_panel_stop_select #(
  parameter int unsigned DISC_CYCLES = rps_pkg::DISC_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic unit_present_pin,
  input wire logic stop_key_pin,
  input wire logic reset_key_pin,
  input wire logic external_reset_input,
  input wire logic stop_reset_key_pin,
  // same-clock drive status
  input wire logic [1:0] op_mode,
  input wire logic rs485_on_connector,
  input wire logic ext_fault,
  // drive control outputs
  output logic fault_out,
  output logic [7:0] fault_code,
  output logic panel_stop_state,
  output logic run_permit,
  output logic decel_stop,
  output logic drive_shutoff,
  output logic reset_pulse,
  output logic clear_thermal,
  output logic clear_regen
);

  typedef struct packed {
    logic [4:0] sel;                 // reset_panel_stop_select
    logic [1:0] wprot;               // write_protect_select
    logic [rps_pkg::PIN_W-1:0] s1;   // first sync stage
    logic [rps_pkg::PIN_W-1:0] s2;   // second sync stage
    logic [rps_pkg::PIN_W-1:0] s3;   // previous value for edges
    rps_pkg::drive_state_e st;       // run / panel stop / trip
    logic [7:0] code;                // latched fault code
    logic [31:0] rdata;              // read data
    logic slverr;                    // bus error
    logic decel;                     // decelerate request
    logic rst_p;                     // accepted reset
    logic shutoff;                   // drive output off
  } top_s;

  // registered state and its next value
  top_s r;
  top_s n;

  // combinational helpers
  // rise marks one cycle per synchronised rising pin edge
  logic [rps_pkg::PIN_W-1:0] rise;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic sel_ok;
  logic trip_only;
  logic detect_sel;
  logic stop_any_mode;
  logic detect_en;
  logic tripped;
  logic disc_trip;
  logic unit_armed;
  logic comm_reset;
  logic src_reset;
  logic key_reset;
  logic accept;
  logic trip_evt;
  logic clear_ok;

  // the selection holds meaning only in its legal windows
  function automatic logic legal_sel(input logic [4:0] v);
    legal_sel = (v <= rps_pkg::SELECT_LOW_MAX) ||
                ((v >= rps_pkg::SELECT_HIGH_MIN) &&
                 (v <= rps_pkg::SELECT_HIGH_MAX));
  endfunction

  // edges read only the second and third stages
  assign rise = r.s2 & ~r.s3;

  // apb phases; zero wait states
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en = access_ph && pwrite;
  // a legal setting also needs all upper bits at zero
  assign sel_ok = legal_sel(pwdata[4:0]) && (pwdata[31:5] == 27'h0);

  // decode of the selection setting
  assign trip_only = r.sel[rps_pkg::SEL_TRIP_ONLY_BIT];
  // bit 1 selects detection in the low window; 14/15 have it set
  // and 16/17 clear, so the high window inverts it
  assign detect_sel = r.sel[rps_pkg::SEL_DETECT_BIT] ^ stop_any_mode;
  assign stop_any_mode = (r.sel >= rps_pkg::SELECT_HIGH_MIN);
  // rs485 through the connector masks only the detection
  assign detect_en = detect_sel && !rs485_on_connector;
  assign tripped = (r.st == rps_pkg::ST_TRIP);

  // reset sources
  assign comm_reset = wr_en && (paddr == rps_pkg::ADDR_CMD) &&
                      pwdata[rps_pkg::CMD_COMMRESET_BIT];
  assign src_reset = rise[rps_pkg::PIN_EXT_RESET] || comm_reset;
  assign key_reset = rise[rps_pkg::PIN_RESET_KEY] && tripped;
  // trip-only settings refuse resets while healthy
  assign accept = (src_reset && (!trip_only || tripped)) ||
                  key_reset;
  // trip sources: unit disconnect or another drive fault
  assign trip_evt = disc_trip || ext_fault;
  // a locked write protection refuses parameter clears
  assign clear_ok = (r.wprot != rps_pkg::WPROT_LOCK);

  // disconnect timer
  // presence reaches the timer already synchronised
  disconnect_timer #(
    .THRESHOLD(DISC_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .detect_en(detect_en),
    .unit_present(r.s2[rps_pkg::PIN_PRESENT]),
    .trip_pulse(disc_trip),
    .armed(unit_armed)
  );

  // next-state logic
  always_comb begin
    n = r;
    // pin synchronisers
    n.s1 = {stop_reset_key_pin, external_reset_input, reset_key_pin,
            stop_key_pin, unit_present_pin};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.decel = 1'b0;
    n.rst_p = 1'b0;

    // apb read data prepared in setup, held through access
    if (setup_ph) begin
      n.rdata = 32'h0;
      n.slverr = 1'b0;
      // decode by address, first match wins
      if (paddr == rps_pkg::ADDR_SELECT) begin
        n.rdata[4:0] = r.sel;
        n.slverr = pwrite && !sel_ok;
      end else if (paddr == rps_pkg::ADDR_WPROT) begin
        n.rdata[1:0] = r.wprot;
        n.slverr = pwrite && ((pwdata[31:2] != 30'h0) ||
                              (pwdata[1:0] > rps_pkg::WPROT_MAX));
      end else if (paddr == rps_pkg::ADDR_CMD) begin
        // command register reads as zero
        n.rdata = 32'h0;
      end else if (paddr == rps_pkg::ADDR_STATUS) begin
        // live snapshot, taken in the setup cycle
        n.rdata[rps_pkg::STAT_FAULT_BIT] = tripped;
        n.rdata[rps_pkg::STAT_PSTOP_BIT] = (r.st == rps_pkg::ST_PSTOP);
        n.rdata[rps_pkg::STAT_PRESENT_BIT] = r.s2[rps_pkg::PIN_PRESENT];
        n.rdata[rps_pkg::STAT_DETECT_BIT] = detect_en;
        n.rdata[rps_pkg::STAT_ARMED_BIT] = unit_armed;
        n.rdata[rps_pkg::STAT_CODE_LSB +: 8] = r.code;
      end else begin
        // unmapped address answers with an error
        n.slverr = 1'b1;
      end
    end

    // register writes take effect in the access phase
    if (wr_en) begin
      if (paddr == rps_pkg::ADDR_SELECT) begin
        // no protection check: setting stays writable while running
        if (sel_ok) begin
          n.sel = pwdata[4:0];
        end
      end else if (paddr == rps_pkg::ADDR_WPROT) begin
        // values above two are refused and keep the old one
        if ((pwdata[31:2] == 30'h0) &&
            (pwdata[1:0] <= rps_pkg::WPROT_MAX)) begin
          n.wprot = pwdata[1:0];
        end
      end else if (paddr == rps_pkg::ADDR_CMD) begin
        // clears restore protection but never the selection
        // command bits are strobes and nothing is stored
        if (clear_ok && (pwdata[rps_pkg::CMD_PCLEAR_BIT] ||
                         pwdata[rps_pkg::CMD_ALLCLEAR_BIT])) begin
          n.wprot = rps_pkg::WPROT_RESET;
        end
      end else begin
        // status and unmapped writes are ignored
        n.wprot = r.wprot;
      end
    end

    // accepted reset returns to run and clears the fault
    if (accept) begin
      n.rst_p = 1'b1;
      // a panel stop is lifted by any accepted reset
      n.st = rps_pkg::ST_RUN;
      n.code = rps_pkg::FAULT_NONE;
    end

    // drive state machine
    case (r.st)
      rps_pkg::ST_RUN: begin
        // only a fresh stop edge acts, never a held key
        if (rise[rps_pkg::PIN_STOP] && !accept) begin
          if (stop_any_mode) begin
            // stop in any mode and hold the stop state
            n.decel = 1'b1;
            n.st = rps_pkg::ST_PSTOP;
          end else if (op_mode == rps_pkg::MODE_PANEL) begin
            // panel mode only, no stop state kept
            n.decel = 1'b1;
          end else begin
            // ignored outside panel mode
            n.decel = 1'b0;
          end
        end
      end
      rps_pkg::ST_PSTOP: begin
        // restart refused until a stop reset or an accepted reset
        if (rise[rps_pkg::PIN_STOP_RESET]) begin
          n.st = rps_pkg::ST_RUN;
        end
      end
      rps_pkg::ST_TRIP: begin
        // leaves only through an accepted reset
        n.st = accept ? rps_pkg::ST_RUN : rps_pkg::ST_TRIP;
      end
      default: begin
        // unused code falls back to the safe state
        n.st = rps_pkg::ST_TRIP;
      end
    endcase

    // a trip in the cycle of a reset still wins unless already tripped
    if (trip_evt && !tripped) begin
      n.st = rps_pkg::ST_TRIP;
      n.code = disc_trip ? rps_pkg::FAULT_PANEL_DISC
                         : rps_pkg::FAULT_EXTERNAL;
    end

    // output off while tripped or being reset, motor coasts
    // a stop request in that cycle never keeps the output on
    n.shutoff = n.rst_p || (n.st == rps_pkg::ST_TRIP);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      // the setting reloads its default only at power-on
      r.sel <= rps_pkg::SELECT_RESET;
      r.wprot <= rps_pkg::WPROT_RESET;
      r.st <= rps_pkg::ST_RUN;
      r.code <= rps_pkg::FAULT_NONE;
    end else begin
      r <= n;
    end
  end

  // bus outputs
  // no wait states, so every access ends at once
  assign pready = 1'b1;
  assign prdata = r.rdata;
  assign pslverr = r.slverr && access_ph;

  // drive outputs
  // run is withheld in the cycle of a reset as well
  assign fault_out = tripped;
  assign fault_code = r.code;
  assign panel_stop_state = (r.st == rps_pkg::ST_PSTOP);
  assign run_permit = (r.st == rps_pkg::ST_RUN) && !r.rst_p;
  assign decel_stop = r.decel;
  assign drive_shutoff = r.shutoff;
  assign reset_pulse = r.rst_p;
  assign clear_thermal = r.rst_p;
  assign clear_regen = r.rst_p;

endmodule
`default_nettype wire

// *** rtl/rps_pkg.sv ***
// constants and types shared by the reset / panel-stop select block
`default_nettype none
package rps_pkg;

  // apb byte addresses
  localparam logic [7:0] ADDR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_WPROT = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // selection setting: reset value and legal windows
  localparam logic [4:0] SELECT_RESET = 5'h0E;
  localparam logic [4:0] SELECT_LOW_MAX = 5'h03;
  localparam logic [4:0] SELECT_HIGH_MIN = 5'h0E;
  localparam logic [4:0] SELECT_HIGH_MAX = 5'h11;
  // selection bit meanings inside the legal windows
  localparam int SEL_TRIP_ONLY_BIT = 0;
  localparam int SEL_DETECT_BIT = 1;

  // write protection setting
  localparam logic [1:0] WPROT_RESET = 2'h0;
  localparam logic [1:0] WPROT_LOCK = 2'h1;
  localparam logic [1:0] WPROT_MAX = 2'h2;

  // command register bit positions
  localparam int CMD_PCLEAR_BIT = 0;
  localparam int CMD_ALLCLEAR_BIT = 1;
  localparam int CMD_COMMRESET_BIT = 2;

  // status register bit positions
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_PSTOP_BIT = 1;
  localparam int STAT_PRESENT_BIT = 2;
  localparam int STAT_DETECT_BIT = 3;
  localparam int STAT_ARMED_BIT = 4;
  localparam int STAT_CODE_LSB = 8;

  // fault codes
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_PANEL_DISC = 8'h01;
  localparam logic [7:0] FAULT_EXTERNAL = 8'h02;

  // disconnect timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DISC_TIME_MS = 1000;
  localparam int unsigned DISC_CYCLES = DISC_TIME_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W = 27;

  // synchronised pin indices
  localparam int PIN_PRESENT = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_RESET_KEY = 2;
  localparam int PIN_EXT_RESET = 3;
  localparam int PIN_STOP_RESET = 4;
  localparam int PIN_W = 5;

  // operation modes
  typedef enum logic [1:0] {
    MODE_PANEL = 2'h0,
    MODE_EXTERNAL = 2'h1,
    MODE_COMM = 2'h2,
    MODE_OTHER = 2'h3
  } op_mode_e;

  // drive state, gray coded along run -> stop -> trip
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_PSTOP = 2'h1,
    ST_TRIP = 2'h3
  } drive_state_e;

endpackage
`default_nettype wire

// *** verif/op_unit_model.sv ***
// behavioural model of the detachable operating unit
`timescale 1ns/1ns
`default_nettype none
module op_unit_model (
  // clock
  input wire logic pclk,
  // pins toward the drive
  output logic present,
  output logic stop_key,
  output logic reset_key,
  output logic stop_reset_key
);
  logic [2:0] keys; // stop, reset, panel-stop reset
  assign stop_key = keys[0];
  assign reset_key = keys[1];
  assign stop_reset_key = keys[2];
  // unit starts unplugged so power-on absence is exercised
  initial begin
    present = 1'b0;
    keys = 3'h0;
  end
  // plug in or pull out the unit
  task automatic plug(input logic on);
    @(posedge pclk);
    present <= on;
  endtask
  // key held long enough to pass the two-stage synchroniser
  task automatic press(input int k);
    @(posedge pclk);
    keys[k] <= 1'b1;
    repeat (5) @(posedge pclk);
    keys[k] <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** verif/reset_panel_stop_select_tb.sv ***
// self-checking bench for the reset / panel-stop select block
`timescale 1ns/1ns
`default_nettype none
module reset_panel_stop_select_tb;
  localparam int unsigned DC = 20; // shortened disconnect time
  logic pclk, presetn, psel, penable, pwrite, ext_rst, rs485, ext_f;
  logic [7:0] paddr;
  logic [1:0] op_mode;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, er, fault_out, pss, decel_stop, reset_pulse;
  logic run_permit, drive_shutoff, clear_thermal, clear_regen;
  logic present, stop_key, reset_key, stop_rst_key;
  logic [7:0] fault_code;
  int bad_count = 0;
  int checks = 0;
  int rp_n = 0; // accepted resets seen
  int ds_n = 0; // stop requests seen
  int cl_n = 0; // paired total clears seen
  int n0, n1;
  always #5 pclk = ~pclk;
  // count strobes at each edge
  always @(posedge pclk) begin
    if (reset_pulse === 1'b1) rp_n++;
    if (decel_stop === 1'b1) ds_n++;
    if (clear_thermal === 1'b1 && clear_regen === 1'b1) cl_n++;
  end
  op_unit_model unit_m (.pclk(pclk), .present(present),
    .stop_key(stop_key), .reset_key(reset_key),
    .stop_reset_key(stop_rst_key));
  reset_panel_stop_select #(.DISC_CYCLES(DC)) uut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unit_present_pin(present), .stop_key_pin(stop_key),
    .reset_key_pin(reset_key), .external_reset_input(ext_rst),
    .stop_reset_key_pin(stop_rst_key), .op_mode(op_mode),
    .rs485_on_connector(rs485), .ext_fault(ext_f), .fault_out(fault_out),
    .fault_code(fault_code), .panel_stop_state(pss),
    .run_permit(run_permit), .decel_stop(decel_stop),
    .drive_shutoff(drive_shutoff), .reset_pulse(reset_pulse),
    .clear_thermal(clear_thermal), .clear_regen(clear_regen));
  // compare and count
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rdv, e);
  endtask
  // reset terminal pulse, slow enough for the synchroniser
  task automatic ext_pulse;
    @(posedge pclk);
    ext_rst <= 1'b1;
    repeat (5) @(posedge pclk);
    ext_rst <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
  // pull the unit and wait past the disconnect time
  task automatic pull;
    unit_m.plug(1'b0);
    repeat (DC + 12) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard, well above the expected run length
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    ext_rst = 1'b0;
    rs485 = 1'b0;
    op_mode = 2'h0;
    ext_f = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(rps_pkg::ADDR_SELECT, 32'h0000000E, "select");
    rd(8'h10, 32'h00000000, "unmapped");
    chk("unmapped err", {31'h0, er}, 32'h00000001);
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000005);
    chk("illegal err", {31'h0, er}, 32'h00000001);
    rd(rps_pkg::ADDR_SELECT, 32'h0000000E, "illegal select");
    // unit absent since power-on must not trip
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000010);
    repeat (3 * DC) @(posedge pclk);
    chk("power-on absence", {31'h0, fault_out}, 32'h0);
    n0 = rp_n;
    ext_pulse();
    chk("reset any time", 32'(rp_n - n0), 32'h1);
    // trip-only setting refuses resets while healthy
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000011);
    n0 = rp_n;
    ext_pulse();
    apb(1'b1, rps_pkg::ADDR_CMD, 32'h00000004);
    repeat (4) @(posedge pclk);
    chk("refused resets", 32'(rp_n - n0), 32'h0);
    unit_m.plug(1'b1);
    repeat (10) @(posedge pclk);
    // no trip until the absence outlasts the threshold
    unit_m.plug(1'b0);
    repeat (DC) @(posedge pclk);
    chk("disc early", {31'h0, fault_out}, 32'h0);
    repeat (12) @(posedge pclk);
    chk("disc trip", {31'h0, fault_out}, 32'h1);
    chk("disc code", {24'h0, fault_code}, 32'h00000001);
    chk("trip off", {30'h0, drive_shutoff, run_permit}, 32'h2);
    rd(rps_pkg::ADDR_STATUS, 32'h00000119, "status trip");
    unit_m.plug(1'b1);
    n0 = rp_n;
    n1 = cl_n;
    apb(1'b1, rps_pkg::ADDR_CMD, 32'h00000004);
    repeat (4) @(posedge pclk);
    chk("comm reset in trip", 32'(rp_n - n0), 32'h1);
    chk("comm clears", 32'(cl_n - n1), 32'h1);
    chk("trip cleared", {31'h0, fault_out}, 32'h0);
    // panel reset key: refused while healthy, taken while tripped
    n0 = rp_n;
    unit_m.press(1);
    chk("key healthy", 32'(rp_n - n0), 32'h0);
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000010);
    pull();
    unit_m.plug(1'b1);
    unit_m.press(1);
    chk("key in trip", 32'(rp_n - n0), 32'h1);
    // detection off by setting, and off under rs485
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h0000000F);
    pull();
    chk("no detect", {31'h0, fault_out}, 32'h0);
    unit_m.plug(1'b1);
    rs485 <= 1'b1;
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000010);
    pull();
    chk("rs485 no detect", {31'h0, fault_out}, 32'h0);
    unit_m.plug(1'b1);
    rs485 <= 1'b0;
    // select writable under lock, untouched by clears
    apb(1'b1, rps_pkg::ADDR_WPROT, 32'h00000001);
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000003);
    rd(rps_pkg::ADDR_SELECT, 32'h00000003, "locked write");
    apb(1'b1, rps_pkg::ADDR_WPROT, 32'h00000000);
    apb(1'b1, rps_pkg::ADDR_CMD, 32'h00000003);
    rd(rps_pkg::ADDR_SELECT, 32'h00000003, "after clears");
    // low settings: stop key only in panel mode
    op_mode <= 2'h1;
    n0 = ds_n;
    unit_m.press(0);
    op_mode <= 2'h0;
    unit_m.press(0);
    chk("low stop", 32'(ds_n - n0), 32'h1);
    chk("no stop state", {31'h0, pss}, 32'h0);
    // high settings: stop key in panel, external and comm modes, held until stop reset
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h0000000E);
    for (int m = 0; m < 3; m++) begin
      op_mode <= 2'(m);
      n0 = ds_n;
      unit_m.press(0);
      chk("high stop", 32'(ds_n - n0), 32'h1);
      unit_m.press(0);
      chk("stop state", {31'h0, pss}, 32'h1);
      unit_m.press(2);
      chk("stop reset", {31'h0, pss}, 32'h0);
    end
    // external trip: coded, output off, cleared by the terminal
    ext_f <= 1'b1;
    @(posedge pclk);
    ext_f <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("ext code", {24'h0, fault_code}, 32'h00000002);
    chk("ext off", {30'h0, drive_shutoff, run_permit}, 32'h2);
    n0 = rp_n;
    n1 = cl_n;
    ext_pulse();
    chk("ext reset", 32'(rp_n - n0), 32'h1);
    chk("ext clears", 32'(cl_n - n1), 32'h1);
    chk("ext cleared", {23'h0, fault_out, fault_code}, 32'h0);
    chk("run again", {31'h0, run_permit}, 32'h1);
    // a power-on reset lifts the stop state and reloads the setting
    apb(1'b1, rps_pkg::ADDR_SELECT, 32'h00000011);
    unit_m.press(0);
    chk("stop held", {31'h0, run_permit}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset stop", {31'h0, pss}, 32'h0);
    rd(rps_pkg::ADDR_SELECT, 32'h0000000E, "reset select");
    close_out();
  end
endmodule
`default_nettype wire

// *** verif/rps_props.sv ***
// port assertions for the reset / panel-stop select block
`timescale 1ns/1ns
`default_nettype none
module rps_props #(
  parameter int unsigned DISC_CYCLES = 20
) (
  // clock, reset and apb handshake
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // drive control outputs
  input wire logic fault_out,
  input wire logic panel_stop_state,
  input wire logic run_permit,
  input wire logic decel_stop,
  input wire logic drive_shutoff,
  input wire logic reset_pulse,
  input wire logic clear_thermal,
  input wire logic clear_regen
);
  // one clock domain, so clocking and disable are shared
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // accepted reset: all three strobes together, for one cycle only
  sequence s_accept;
    reset_pulse && clear_thermal && clear_regen ##1 !reset_pulse;
  endsequence
  // stop request is a single-cycle strobe
  sequence s_decel;
    decel_stop ##1 !decel_stop;
  endsequence
  AST_PULSE_ONE: assert property (reset_pulse |-> s_accept)
    else $error("reset strobe not a single cycle");
  AST_CLEARS: assert property (
    (clear_thermal || clear_regen) |-> s_accept)
    else $error("totals cleared without an accepted reset");
  AST_SHUTOFF: assert property (
    reset_pulse |-> drive_shutoff && !run_permit)
    else $error("output not shut off on accepted reset");
  AST_TRIP_OFF: assert property (
    fault_out |-> drive_shutoff && !run_permit)
    else $error("drive running while tripped");
  AST_DECEL_ONE: assert property (decel_stop |-> s_decel)
    else $error("stop request not a single cycle");
  AST_STOP_BLOCKS: assert property (
    panel_stop_state |-> !run_permit)
    else $error("run permitted in panel stop");
  AST_STOP_ENTRY: assert property (
    $rose(panel_stop_state) |-> decel_stop)
    else $error("panel stop entered without a stop request");
  AST_TRIP_EXIT: assert property ($fell(fault_out) |-> reset_pulse)
    else $error("trip left without an accepted reset");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("bus error outside the access phase");
endmodule
bind reset_panel_stop_select rps_props #(.DISC_CYCLES(DISC_CYCLES))
  u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pslverr(pslverr), .fault_out(fault_out),
  .panel_stop_state(panel_stop_state), .run_permit(run_permit),
  .decel_stop(decel_stop), .drive_shutoff(drive_shutoff),
  .reset_pulse(reset_pulse), .clear_thermal(clear_thermal),
  .clear_regen(clear_regen));
`default_nettype wire
